// >>> zsr_consts.svh
// Constants for the pipelined zero-turnaround static memory and its host.
// Assumes inclusion by bare name from the interface, host, memory and bench files.
`ifndef ZSR_CONSTS_SVH
`define ZSR_CONSTS_SVH
// Array shape: 4 lanes of 9 bits with 19 address bits, or 2 with 20
`define ZSR_LANES 4
`define ZSR_ADDR_W 19
`define ZSR_LANE_W 9
// Host register byte offsets on the 32-bit bus
`define ZSR_AV_AW 5
`define ZSR_OFS_CTRL 5'h00
`define ZSR_OFS_CMD 5'h04
`define ZSR_OFS_ADDR 5'h08
`define ZSR_OFS_WDLO 5'h0C
`define ZSR_OFS_WDHI 5'h10
`define ZSR_OFS_RDLO 5'h14
`define ZSR_OFS_RDHI 5'h18
`define ZSR_OFS_STAT 5'h1C
// Control register fields
`define ZSR_CTRL_ORDER 0
`define ZSR_CTRL_SLEEP 1
`define ZSR_CTRL_ODIS 2
`define ZSR_CTRL_HOLD 3
`define ZSR_CTRL_RST 4'h0
// Command register fields: op in [1:0], byte enables from bit 8
`define ZSR_CMD_BE_LSB 8
// Status register fields
`define ZSR_STAT_RDV 0
`define ZSR_STAT_BUSY 1
`endif

// >>> zsr_pkg.sv
// Types used by the controller end of the static memory link.
// Assumes nothing beyond the constants header.
package zsr_pkg;
  // Pin cycle kinds the host can place on the link
  typedef enum logic [1:0] {
    ZSR_OP_DESEL = 2'h0,
    ZSR_OP_READ = 2'h1,
    ZSR_OP_WRITE = 2'h2,
    ZSR_OP_ADV = 2'h3
  } zsr_op_t;
endpackage : zsr_pkg

// >>> zsr_if.sv
// Link between the memory controller and the static memory.
// Assumes both ends run on the same clock; resolves the shared data bus.
`timescale 1ns/100ps
`include "zsr_consts.svh"
interface zsr_if #(
  parameter int LANES = `ZSR_LANES,
  parameter int ADDR_W = `ZSR_ADDR_W
) (
  input wire logic clk // Shared link clock
);
  localparam int DATA_W = LANES * `ZSR_LANE_W;
  logic [ADDR_W-1:0] addr;
  logic select_low_a;
  logic select_low_b;
  logic select_high;
  logic advance_or_load;
  logic read_not_write;
  logic [LANES-1:0] byte_write_n;
  logic burst_order_sel;
  logic output_drive_n;
  logic sleep_request;
  logic clock_hold_n;
  logic [DATA_W-1:0] dq_h2d;
  logic dq_h2d_oe;
  logic [DATA_W-1:0] dq_d2h;
  logic dq_d2h_oe;
  logic [DATA_W-1:0] dq;
  // Wire level from the enables; an undriven bus reads as zero
  assign dq = dq_d2h_oe ? dq_d2h : (dq_h2d_oe ? dq_h2d : '0);
  modport mem (
    input addr, select_low_a, select_low_b, select_high, advance_or_load,
    input read_not_write, byte_write_n, burst_order_sel, output_drive_n,
    input sleep_request, clock_hold_n, dq,
    output dq_d2h, dq_d2h_oe
  );
  modport ctl (
    output addr, select_low_a, select_low_b, select_high, advance_or_load,
    output read_not_write, byte_write_n, burst_order_sel, output_drive_n,
    output sleep_request, clock_hold_n, dq_h2d, dq_h2d_oe,
    input dq
  );
endinterface : zsr_if

// >>> zsr_host.sv
// Memory controller end: Avalon-MM register slave driving the memory link.
// Assumes the memory shares clk and clk_en, and that bursts are written
// as back-to-back command writes.
`timescale 1ns/100ps
`include "zsr_consts.svh"
module zsr_host #(
  parameter int LANES = `ZSR_LANES,
  parameter int ADDR_W = `ZSR_ADDR_W
) (
  input wire logic clk, // 50 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic [`ZSR_AV_AW-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  zsr_if.ctl bus // Memory link
);
  localparam int DATA_W = LANES * `ZSR_LANE_W;
  logic hfreeze;
  logic cmd_wr;
  logic cmd_acc;
  logic rd_pend_q;
  logic [3:0] ctrl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [63:0] wd_q;
  logic [63:0] rdat_q;
  logic rdv_q;
  logic [31:0] rdmux;
  zsr_pkg::zsr_op_t op;
  logic h_act_q, h_wr_q;
  logic pin_acc_q, pin_wr_q, p1_acc_q, p1_wr_q, p2_rd_q;
  logic [DATA_W-1:0] pin_wd_q, p1_wd_q;
  logic [DATA_W-1:0] h2d_q;
  logic h2d_oe_q;

  //////////////////////////////////////////////////////////////////////////
  // Bus handshake; pin state freezes with the hold and sleep pins
  assign hfreeze = !clk_en | ctrl_q[`ZSR_CTRL_HOLD] | ctrl_q[`ZSR_CTRL_SLEEP];
  assign cmd_wr = avs_write & (avs_address == `ZSR_OFS_CMD);
  // Reads take one wait cycle so read data comes from a flop
  assign avs_waitrequest = !clk_en | (avs_read & !rd_pend_q) |
                           (cmd_wr & hfreeze);
  assign cmd_acc = cmd_wr & !avs_waitrequest;
  assign op = zsr_pkg::zsr_op_t'(avs_writedata[1:0]);

  // Register read mux, decoded by offset
  always_comb begin
    rdmux = 32'h0000_0000;
    if (avs_address == `ZSR_OFS_CTRL) begin
      rdmux[3:0] = ctrl_q;
    end else if (avs_address == `ZSR_OFS_ADDR) begin
      rdmux[ADDR_W-1:0] = addr_q;
    end else if (avs_address == `ZSR_OFS_WDLO) begin
      rdmux = wd_q[31:0];
    end else if (avs_address == `ZSR_OFS_WDHI) begin
      rdmux = wd_q[63:32];
    end else if (avs_address == `ZSR_OFS_RDLO) begin
      rdmux = rdat_q[31:0];
    end else if (avs_address == `ZSR_OFS_RDHI) begin
      rdmux = rdat_q[63:32];
    end else if (avs_address == `ZSR_OFS_STAT) begin
      rdmux[`ZSR_STAT_RDV] = rdv_q;
      rdmux[`ZSR_STAT_BUSY] = pin_acc_q | p1_acc_q | h2d_oe_q | p2_rd_q;
    end
  end

  // Read answer register and the one-cycle wait
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      rd_pend_q <= avs_read & !rd_pend_q;
      if (avs_read & !rd_pend_q) begin
        avs_readdata <= rdmux;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `ZSR_CTRL_RST;
      addr_q <= '0;
      wd_q <= 64'h0000_0000_0000_0000;
    end else if (clk_en & avs_write) begin
      if (avs_address == `ZSR_OFS_CTRL) begin
        ctrl_q <= avs_writedata[3:0];
      end else if (avs_address == `ZSR_OFS_ADDR) begin
        addr_q <= avs_writedata[ADDR_W-1:0];
      end else if (avs_address == `ZSR_OFS_WDLO) begin
        wd_q[31:0] <= avs_writedata;
      end else if (avs_address == `ZSR_OFS_WDHI) begin
        wd_q[63:32] <= avs_writedata;
      end
    end
  end

  // Static pins straight from control; order stays fixed in use
  assign bus.burst_order_sel = ctrl_q[`ZSR_CTRL_ORDER];
  assign bus.sleep_request = ctrl_q[`ZSR_CTRL_SLEEP];
  assign bus.output_drive_n = ctrl_q[`ZSR_CTRL_ODIS];
  assign bus.clock_hold_n = ctrl_q[`ZSR_CTRL_HOLD];

  //////////////////////////////////////////////////////////////////////////
  // Pin cycle: deselect unless a command was accepted this cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.addr <= '0;
      bus.advance_or_load <= 1'b0;
      bus.select_low_a <= 1'b1;
      bus.select_low_b <= 1'b1;
      bus.select_high <= 1'b0;
      bus.read_not_write <= 1'b1;
      bus.byte_write_n <= '1;
      h_act_q <= 1'b0;
      h_wr_q <= 1'b0;
      pin_acc_q <= 1'b0;
      pin_wr_q <= 1'b0;
      pin_wd_q <= '0;
    end else if (!hfreeze) begin
      bus.advance_or_load <= cmd_acc & (op == zsr_pkg::ZSR_OP_ADV);
      bus.select_low_a <= !cmd_acc | (op == zsr_pkg::ZSR_OP_DESEL);
      bus.select_low_b <= !cmd_acc | (op == zsr_pkg::ZSR_OP_DESEL);
      bus.select_high <= cmd_acc & (op != zsr_pkg::ZSR_OP_DESEL);
      bus.read_not_write <=
          !(cmd_acc & (op == zsr_pkg::ZSR_OP_WRITE));
      bus.byte_write_n <= cmd_acc ?
          ~avs_writedata[`ZSR_CMD_BE_LSB +: LANES] : '1;
      bus.addr <= addr_q;
      pin_wd_q <= wd_q[DATA_W-1:0];
      // Mirror the memory's burst tracking
      if (cmd_acc & (op == zsr_pkg::ZSR_OP_READ ||
                     op == zsr_pkg::ZSR_OP_WRITE)) begin
        h_act_q <= 1'b1;
        h_wr_q <= (op == zsr_pkg::ZSR_OP_WRITE);
        pin_acc_q <= 1'b1;
        pin_wr_q <= (op == zsr_pkg::ZSR_OP_WRITE);
      end else if (cmd_acc & (op == zsr_pkg::ZSR_OP_ADV)) begin
        pin_acc_q <= h_act_q;
        pin_wr_q <= h_wr_q;
      end else begin
        h_act_q <= 1'b0;
        pin_acc_q <= 1'b0;
        pin_wr_q <= 1'b0;
      end
    end
  end

  // Two-stage data pipeline: drive write data, then catch read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      p1_acc_q <= 1'b0;
      p1_wr_q <= 1'b0;
      p1_wd_q <= '0;
      h2d_q <= '0;
      h2d_oe_q <= 1'b0;
      p2_rd_q <= 1'b0;
    end else if (!hfreeze) begin
      p1_acc_q <= pin_acc_q;
      p1_wr_q <= pin_wr_q;
      p1_wd_q <= pin_wd_q;
      h2d_q <= p1_wd_q;
      h2d_oe_q <= p1_acc_q & p1_wr_q;
      p2_rd_q <= p1_acc_q & !p1_wr_q;
    end
  end
  assign bus.dq_h2d = h2d_q;
  assign bus.dq_h2d_oe = h2d_oe_q;

  // Read capture; a new word wins over the clear by a data read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdat_q <= 64'h0000_0000_0000_0000;
      rdv_q <= 1'b0;
    end else if (clk_en) begin
      if (!hfreeze & p2_rd_q) begin
        rdat_q <= 64'(bus.dq);
        rdv_q <= 1'b1;
      end else if (avs_read & rd_pend_q &
                   (avs_address == `ZSR_OFS_RDLO)) begin
        rdv_q <= 1'b0;
      end
    end
  end
endmodule : zsr_host

// >>> zsr_sram.sv
// Memory end: pipelined static array with burst counter and byte lanes.
// Assumes the controller on the link shares clk; clk_en freezes all state.
`timescale 1ns/100ps
`include "zsr_consts.svh"
module zsr_sram #(
  parameter int LANES = `ZSR_LANES, // 4 for x36, 2 for x18
  parameter int ADDR_W = `ZSR_ADDR_W // 19 for x36, 20 for x18
) (
  input wire logic clk, // 50 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clk_en, // Freezes all state while low
  zsr_if.mem bus // Memory link
);
  localparam int LW = `ZSR_LANE_W;
  localparam int DATA_W = LANES * LW;

  logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
  logic freeze;
  logic sel;
  logic load;
  logic start;
  logic adv_ok;
  logic [1:0] cnt_d;
  logic [ADDR_W-1:0] adv_addr;
  logic [ADDR_W-1:0] base_q;
  logic [1:0] cnt_q;
  logic burst_act_q;
  logic burst_wr_q;
  logic s1_v_q, s1_wr_q, s2_v_q, s2_wr_q;
  logic [ADDR_W-1:0] s1_addr_q, s2_addr_q;
  logic [LANES-1:0] s1_be_q, s2_be_q;
  logic [DATA_W-1:0] rd_q;
  logic oe_q;
  logic [DATA_W-1:0] rd_word;
  logic rd_go; // Read leaving stage one
  logic wr_go; // Write landing at this edge

  //////////////////////////////////////////////////////////////////////////
  // Low two address bits of a burst beat
  function automatic logic [1:0] beat_low(input logic [1:0] base,
                                          input logic [1:0] cnt,
                                          input logic ilv);
    beat_low = ilv ? (base ^ cnt) : 2'(base + cnt);
  endfunction : beat_low

  // Replace enabled lanes of a word with new data
  function automatic logic [DATA_W-1:0] lane_merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [LANES-1:0] be);
    lane_merge = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (be[l]) begin
        lane_merge[l*LW +: LW] = new_w[l*LW +: LW];
      end
    end
  endfunction : lane_merge

  // Lane write enables; a read beat writes nothing
  function automatic logic [LANES-1:0] lane_en(
      input logic wr,
      input logic [LANES-1:0] be_n);
    lane_en = wr ? ~be_n : '0;
  endfunction : lane_en

  //////////////////////////////////////////////////////////////////////////
  // Cycle decode; sleep gates the clock, hold blocks the edge
  // Sleep is a full freeze too, so no beat is lost across it
  assign freeze = !clk_en | bus.clock_hold_n |
                  bus.sleep_request;
  // All three selects must be true at once to start an access
  assign sel = !bus.select_low_a & !bus.select_low_b & bus.select_high;
  assign load = !bus.advance_or_load;
  assign start = load & sel;
  assign adv_ok = !load & burst_act_q;
  assign cnt_d = 2'(cnt_q + 2'h1);
  // Address pins play no part in an advance beat
  assign adv_addr = {base_q[ADDR_W-1:2],
                     beat_low(base_q[1:0], cnt_d,
                              bus.burst_order_sel)};

  // Stage one read and stage two write, shared by the data path
  assign rd_go = s1_v_q & !s1_wr_q;
  assign wr_go = s2_v_q & s2_wr_q;

  // Burst tracking: loaded base, beat count and direction
  // A deselected load drops the burst, so a later advance finds none
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_q <= '0;
      cnt_q <= 2'h0;
      burst_act_q <= 1'b0;
      burst_wr_q <= 1'b0;
    end else if (!freeze) begin
      if (start) begin
        base_q <= bus.addr;
        cnt_q <= 2'h0;
        burst_act_q <= 1'b1;
        burst_wr_q <= !bus.read_not_write;
      end else if (load) begin
        burst_act_q <= 1'b0;
      end else if (burst_act_q) begin
        cnt_q <= cnt_d;
      end
    end
  end

  // Stage one: the access taken at this edge
  // Loads sample the pins; advances reuse the loaded direction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_v_q <= 1'b0;
      s1_wr_q <= 1'b0;
      s1_addr_q <= '0;
      s1_be_q <= '0;
    end else if (!freeze) begin
      if (start) begin
        s1_v_q <= 1'b1;
        s1_wr_q <= !bus.read_not_write;
        s1_addr_q <= bus.addr;
        s1_be_q <= lane_en(!bus.read_not_write, bus.byte_write_n);
      end else if (adv_ok) begin
        s1_v_q <= 1'b1;
        s1_wr_q <= burst_wr_q;
        s1_addr_q <= adv_addr;
        s1_be_q <= lane_en(burst_wr_q, bus.byte_write_n);
      end else begin
        s1_v_q <= 1'b0;
      end
    end
  end

  // Stage two: in-flight accesses finish even after a deselect
  // Selects are not looked at here, so a deselect cannot cut a beat
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s2_v_q <= 1'b0;
      s2_wr_q <= 1'b0;
      s2_addr_q <= '0;
      s2_be_q <= '0;
    end else if (!freeze) begin
      s2_v_q <= s1_v_q;
      s2_wr_q <= s1_wr_q;
      s2_addr_q <= s1_addr_q;
      s2_be_q <= s1_be_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read word, forwarding a write that lands on the same edge
  // Without it a read right after a write would see stale bytes
  always_comb begin
    rd_word = mem_q[s1_addr_q];
    if (wr_go & (s2_addr_q == s1_addr_q)) begin
      rd_word = lane_merge(rd_word, bus.dq, s2_be_q);
    end
  end

  // Output register: drives the bus in the second cycle after the load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= '0;
      oe_q <= 1'b0;
    end else if (!freeze) begin
      oe_q <= rd_go;
      if (rd_go) begin
        rd_q <= rd_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Array write from bus data sampled at the transfer edge
  // No reset here: contents survive reset, hold and sleep alike
  always_ff @(posedge clk) begin
    if (!freeze & wr_go) begin
      for (int l = 0; l < LANES; l++) begin
        if (s2_be_q[l]) begin
          mem_q[s2_addr_q][l*LW +: LW] <= bus.dq[l*LW +: LW];
        end
      end
    end
  end

  // Output disable needs no clock; tying it low is safe
  // The pipeline times the release itself, so the pin is optional
  assign bus.dq_d2h = rd_q;
  assign bus.dq_d2h_oe = oe_q & !bus.output_drive_n;
endmodule : zsr_sram

// >>> zsr_monitor.sv
// Assertion checker for the static memory link between both ends.
// Assumes it sees the link signals directly, all in one clock domain.
`timescale 1ns/100ps
module zsr_monitor (
  input wire logic clk, // Link clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clk_en, // Shared freeze, both ends
  input wire logic select_low_a, // Select, active low
  input wire logic select_low_b, // Select, active low
  input wire logic select_high, // Select, active high
  input wire logic advance_or_load, // 1 advance, 0 load
  input wire logic read_not_write, // 1 read
  input wire logic output_drive_n, // High releases the bus
  input wire logic sleep_request, // Sleep, freezes the memory
  input wire logic clock_hold_n, // High blocks the edge
  input wire logic dq_h2d_oe, // Host drives the bus
  input wire logic dq_d2h_oe // Memory drives the bus
);
  logic act, sel, ld_rd, ld_wr, desel, adv;
  //////////////////////////////////////////////////////////////////////////
  // An edge counts only when nothing freezes it
  assign act = clk_en && !clock_hold_n && !sleep_request;
  assign sel = !select_low_a && !select_low_b && select_high;
  assign ld_rd = act && !advance_or_load && sel && read_not_write;
  assign ld_wr = act && !advance_or_load && sel && !read_not_write;
  assign desel = act && !advance_or_load && !sel;
  assign adv = act && advance_or_load;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////
  // Data phase two unfrozen edges after the load
  a_read_lag: assert property (
    ld_rd ##1 act |=> dq_d2h_oe || output_drive_n)
    else $error("No read drive two cycles after load");
  a_write_lag: assert property (
    ld_wr ##1 act |=> dq_h2d_oe && !dq_d2h_oe)
    else $error("No write drive two cycles after load");
  a_burst_beat: assert property (
    ld_rd ##1 adv ##1 act |=> dq_d2h_oe || output_drive_n)
    else $error("Burst beat missing on the bus");
  a_desel_release: assert property (
    desel ##1 act |=> !dq_d2h_oe)
    else $error("Bus still driven after deselect");
  a_idle_adv: assert property (
    desel ##1 adv ##1 act |=> !dq_d2h_oe && !dq_h2d_oe)
    else $error("Advance after idle moved data");
  // Asynchronous release wins over the pipeline
  a_odis_release: assert property (
    output_drive_n |-> !dq_d2h_oe)
    else $error("Memory drives while output disabled");
  a_no_clash: assert property (
    !(dq_d2h_oe && dq_h2d_oe))
    else $error("Both ends drive the bus");
  // A blocked edge leaves the driver untouched
  a_hold_still: assert property (
    clock_hold_n ##1 $stable(output_drive_n) |-> $stable(dq_d2h_oe))
    else $error("Output moved on a held edge");
  a_sleep_still: assert property (
    sleep_request ##1 $stable(output_drive_n) |-> $stable(dq_d2h_oe))
    else $error("Output moved while asleep");
  c_read: cover property (ld_rd ##1 adv);
  c_write: cover property (ld_wr ##1 adv);
  c_hold: cover property (clock_hold_n ##1 clock_hold_n);
endmodule : zsr_monitor

// >>> testbench.sv
// Self-checking bench: controller and memory joined by the link.
// Assumes one 50 MHz clock; registers reached over Avalon-MM.
`timescale 1ns/100ps
`include "zsr_consts.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] exp_q [$];
  logic [35:0] mem [int];
  logic [31:0] seed = 32'h0000_1c6d;
  int n_fail = 0;
  int total_checks = 0;
  int ord = 0;
  always #10 clk = ~clk;
  zsr_if bus_if (.clk(clk));
  zsr_host zsr_host_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus(bus_if));
  zsr_sram zsr_sram_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .bus(bus_if));
  zsr_monitor zsr_monitor_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .select_low_a(bus_if.select_low_a), .select_low_b(bus_if.select_low_b),
    .select_high(bus_if.select_high), .dq_h2d_oe(bus_if.dq_h2d_oe),
    .advance_or_load(bus_if.advance_or_load), .dq_d2h_oe(bus_if.dq_d2h_oe),
    .read_not_write(bus_if.read_not_write),
    .output_drive_n(bus_if.output_drive_n),
    .sleep_request(bus_if.sleep_request),
    .clock_hold_n(bus_if.clock_hold_n));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [35:0] rnd36();
    logic [31:0] h;
    h = rnd();
    return {h[3:0], rnd()};
  endfunction : rnd36
  // Burst beat n from low bits b0, in the order now set
  function automatic int nx(input int b0, input int n);
    return (ord != 0) ? (b0 ^ n) : ((b0 + n) & 3);
  endfunction : nx
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // One Avalon request held until waitrequest is seen low at an edge
  task automatic req(input logic [4:0] a, input logic [31:0] d,
                     input logic r);
    int n;
    logic w;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    n = 0;
    do begin
      @(negedge clk);
      w = avs_waitrequest;
      @(posedge clk);
      n++;
    end while (w !== 1'b0 && n < 200);
    if (w !== 1'b0) begin
      n_fail++;
      results();
    end
  endtask : req
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    req(a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    req(a, 32'h0000_0000, 1'b1);
  endtask : rd
  task automatic idle(input int k);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (k) @(posedge clk);
  endtask : idle
  task automatic cmd(input logic [1:0] op, input logic [3:0] be);
    wr(`ZSR_OFS_CMD, {20'h0_0000, be, 6'h00, op});
  endtask : cmd
  task automatic upd(input int a, input logic [35:0] d,
                     input logic [3:0] be);
    for (int l = 0; l < 4; l++) begin
      if (be[l]) mem[a][9*l+:9] = d[9*l+:9];
    end
  endtask : upd
  task automatic load_wd(input int a, input logic [35:0] d);
    wr(`ZSR_OFS_ADDR, 32'(a));
    wr(`ZSR_OFS_WDLO, d[31:0]);
    wr(`ZSR_OFS_WDHI, {28'h000_0000, d[35:32]});
  endtask : load_wd
  task automatic sw(input int a, input logic [35:0] d, input logic [3:0] be);
    load_wd(a, d);
    cmd(2'h2, be);
    upd(a, d, be);
  endtask : sw
  // Single read, optionally deselected on the very next cycle
  task automatic chk(input int a, input bit ds);
    wr(`ZSR_OFS_ADDR, 32'(a));
    cmd(2'h1, 4'h0);
    if (ds) cmd(2'h0, 4'h0);
    idle(6);
    rd(`ZSR_OFS_STAT, 32'h0000_0001);
    rd(`ZSR_OFS_RDLO, mem[a][31:0]);
    rd(`ZSR_OFS_RDHI, {28'h000_0000, mem[a][35:32]});
  endtask : chk
  //////////////////////////////////////////////////////////////////////////
  // Oldest expectation meets each read answer
  always @(negedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      total_checks++;
      if (exp_q.size() == 0 || avs_readdata !== exp_q[0]) begin
        n_fail++;
        $display("BAD readdata exp %h seen %h", exp_q[0], avs_readdata);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    int a;
    logic [35:0] d;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`ZSR_OFS_CTRL, 32'h0000_0000);
    rd(5'h02, 32'h0000_0000);
    a = int'(rnd() & 32'h0007_fffc);
    sw(a, rnd36(), 4'hf);
    // Lane masks from none to all, one read deselected at once
    for (int i = 0; i < 16; i += 5) begin
      sw(a, rnd36(), 4'(i));
      chk(a, i == 5);
    end
    // Order is changed only while the link is idle
    for (int o = 0; o < 2; o++) begin
      wr(`ZSR_OFS_CTRL, 32'(o));
      ord = o;
      a = int'(rnd() & 32'h0007_fffc);
      for (int b = 0; b < 4; b++) sw(a + b, rnd36(), 4'hf);
      d = rnd36();
      load_wd(a + 1, d);
      cmd(2'h2, 4'hf);
      cmd(2'h3, 4'hf);
      upd(a + 1, d, 4'hf);
      upd(a + nx(1, 1), d, 4'hf);
      for (int b = 0; b < 4; b++) chk(a + b, 1'b0);
      wr(`ZSR_OFS_ADDR, 32'(a + 1));
      cmd(2'h1, 4'h0);
      for (int b = 0; b < 3; b++) cmd(2'h3, 4'h0);
      idle(6);
      rd(`ZSR_OFS_RDLO, mem[a + nx(1, 3)][31:0]);
    end
    // Load then deselect ends the burst; a lone advance does nothing
    d = rnd36();
    load_wd(a + 1, d);
    cmd(2'h2, 4'hf);
    cmd(2'h0, 4'h0);
    cmd(2'h3, 4'hf);
    idle(2);
    cmd(2'h3, 4'hf);
    upd(a + 1, d, 4'hf);
    for (int b = 0; b < 4; b++) chk(a + b, 1'b0);
    // Freeze by clock enable, sleep and hold with a read in flight
    for (int k = 0; k < 3; k++) begin
      sw(a, rnd36(), 4'hf);
      wr(`ZSR_OFS_ADDR, 32'(a));
      cmd(2'h1, 4'h0);
      if (k == 0) begin
        avs_write <= 1'b0;
        clk_en <= 1'b0;
        repeat (4) @(posedge clk);
        clk_en <= 1'b1;
      end else begin
        wr(`ZSR_OFS_CTRL, 32'(ord) | ((k == 1) ? 32'h2 : 32'h8));
        idle(5);
        wr(`ZSR_OFS_CTRL, 32'(ord));
      end
      idle(6);
      rd(`ZSR_OFS_STAT, 32'h0000_0001);
      rd(`ZSR_OFS_RDLO, mem[a][31:0]);
    end
    // Released bus reads as the undriven level
    wr(`ZSR_OFS_CTRL, 32'(ord) | 32'h4);
    wr(`ZSR_OFS_ADDR, 32'(a));
    cmd(2'h1, 4'h0);
    rd(`ZSR_OFS_STAT, 32'h0000_0002);
    idle(6);
    rd(`ZSR_OFS_RDLO, 32'h0000_0000);
    wr(`ZSR_OFS_CTRL, 32'(ord));
    idle(4);
    results();
  end
endmodule : testbench
